// ### rtl/msl_consts.svh
// constants for the status led driver: offsets, fields, resets, timing
`ifndef MSL_CONSTS_SVH
`define MSL_CONSTS_SVH
`define MSL_CLK_HZ          100000000
`define MSL_SLOW_HZ_X10     5
`define MSL_FAST_HZ_X10     20
`define MSL_SLOW_HALF_CYC   ((`MSL_CLK_HZ * 10) / (`MSL_SLOW_HZ_X10 * 2))
`define MSL_FAST_HALF_CYC   ((`MSL_CLK_HZ * 10) / (`MSL_FAST_HZ_X10 * 2))
`define MSL_IDENT_HZ_X10    20
`define MSL_IDENT_HALF_CYC  ((`MSL_CLK_HZ * 10) / (`MSL_IDENT_HZ_X10 * 2))
`define MSL_OFF_CTRL        12'h000
`define MSL_OFF_STATUS      12'h004
`define MSL_CTRL_IDENT_BIT  0
`define MSL_ST_GREEN_BIT    0
`define MSL_ST_RED_BIT      1
`define MSL_ST_MODE_LSB     2
`define MSL_CTRL_RESET      32'h0000_0000
`endif

// ### rtl/msl_pkg.sv
// types for the status led driver
`default_nettype none
package msl_pkg;
	typedef enum logic [6:0]
	{
		MSL_DARK     = 7'h01,
		MSL_GREEN    = 7'h02,
		MSL_ORANGE   = 7'h04,
		MSL_RED      = 7'h08,
		MSL_DL_SLOW  = 7'h10,
		MSL_DL_FAST  = 7'h20,
		MSL_IDENT    = 7'h40
	} msl_mode_t;
endpackage
`default_nettype wire

// ### rtl/msl_status_led.sv
// status led driver with apb control registers
`timescale 1ns/100ps
`default_nettype none
`include "msl_consts.svh"
// Overview of operation
// - steady green when operational and cyclic link traffic runs.
// - steady orange while link is being set up, not yet cyclic.
// - steady red while any fault is active, clearing one clock after fault_active_in drops.
// - red fault shown regardless of message reconfiguration.
// - green/red alternate at 0.5 Hz during firmware download.
// - green/red alternate at 2 Hz after download, until power cycle.
// - identify flashes green/orange or red/orange, chosen at switch-on.
module msl_status_led
(
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	// condition inputs from module logic
	input  wire logic                oper_ready_in,
	input  wire logic                link_cyclic_in,
	input  wire logic                link_setup_in,
	input  wire logic                fault_active_in,
	input  wire logic                msg_reconfig_in,
	input  wire logic                fw_dl_busy_in,
	input  wire logic                fw_dl_done_in,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// led drive
	output logic                     led_green_out,
	output logic                     led_red_out,
	output var msl_pkg::msl_mode_t   led_mode_out
);
	import msl_pkg::*;

	localparam int SLOW_HALF  = `MSL_SLOW_HALF_CYC;
	localparam int FAST_HALF  = `MSL_FAST_HALF_CYC;
	localparam int IDENT_HALF = `MSL_IDENT_HALF_CYC;

	logic             led_identify_setting_reg;
	logic             ident_red_base_reg;
	logic             dl_done_latch_reg;
	logic [27:0]      slow_cnt_reg;
	logic [27:0]      fast_cnt_reg;
	logic [27:0]      ident_cnt_reg;
	logic             slow_ph_reg;
	logic             fast_ph_reg;
	logic             ident_ph_reg;
	msl_mode_t        mode_next;
	logic             green_next;
	logic             red_next;
	logic             apb_acc;

	function automatic logic [27:0] cnt_step(input logic [27:0] c, input int half);
		cnt_step = (c == 28'(half - 1)) ? 28'h0000000 : c + 28'h0000001;
	endfunction

	assign apb_acc = psel && penable;

	// apb: zero wait states, unmapped address answers slverr
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr != `MSL_OFF_CTRL && paddr != `MSL_OFF_STATUS;
			if (psel && !penable && !pwrite)
			begin
				if (paddr == `MSL_OFF_CTRL)
					prdata <= {31'h0, led_identify_setting_reg};
				else if (paddr == `MSL_OFF_STATUS)
					prdata <= {23'h0, led_mode_out, led_red_out, led_green_out};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end

	// identify setting, written by software
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			led_identify_setting_reg <= 1'b0;
		else if (apb_acc && pready && pwrite && paddr == `MSL_OFF_CTRL)
			led_identify_setting_reg <= pwdata[`MSL_CTRL_IDENT_BIT];
	end

	// base colour captured when identify switches on
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ident_red_base_reg <= 1'b0;
		else if (apb_acc && pready && pwrite && paddr == `MSL_OFF_CTRL
			&& pwdata[`MSL_CTRL_IDENT_BIT] && !led_identify_setting_reg)
			ident_red_base_reg <= led_red_out;
	end

	// download complete holds until power cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			dl_done_latch_reg <= 1'b0;
		else if (fw_dl_done_in)
			dl_done_latch_reg <= 1'b1;
	end

	// flash dividers
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			slow_cnt_reg  <= 28'h0000000;
			fast_cnt_reg  <= 28'h0000000;
			ident_cnt_reg <= 28'h0000000;
			slow_ph_reg   <= 1'b0;
			fast_ph_reg   <= 1'b0;
			ident_ph_reg  <= 1'b0;
		end
		else
		begin
			slow_cnt_reg  <= cnt_step(slow_cnt_reg, SLOW_HALF);
			fast_cnt_reg  <= cnt_step(fast_cnt_reg, FAST_HALF);
			ident_cnt_reg <= cnt_step(ident_cnt_reg, IDENT_HALF);
			if (slow_cnt_reg == 28'(SLOW_HALF - 1))
				slow_ph_reg <= !slow_ph_reg;
			if (fast_cnt_reg == 28'(FAST_HALF - 1))
				fast_ph_reg <= !fast_ph_reg;
			if (ident_cnt_reg == 28'(IDENT_HALF - 1))
				ident_ph_reg <= !ident_ph_reg;
		end
	end

	// pattern selection by priority
	always_comb
	begin
		mode_next  = MSL_DARK;
		green_next = 1'b0;
		red_next   = 1'b0;
		if (led_identify_setting_reg)
		begin
			mode_next  = MSL_IDENT;
			green_next = ident_ph_reg ? 1'b1 : !ident_red_base_reg;
			red_next   = ident_ph_reg ? 1'b1 : ident_red_base_reg;
		end
		else if (dl_done_latch_reg)
		begin
			mode_next  = MSL_DL_FAST;
			green_next = !fast_ph_reg;
			red_next   = fast_ph_reg;
		end
		else if (fw_dl_busy_in)
		begin
			mode_next  = MSL_DL_SLOW;
			green_next = !slow_ph_reg;
			red_next   = slow_ph_reg;
		end
		else if (fault_active_in)
		begin
			mode_next = MSL_RED;
			red_next  = 1'b1;
		end
		else if (link_setup_in || (oper_ready_in && !link_cyclic_in))
		begin
			mode_next  = MSL_ORANGE;
			green_next = 1'b1;
			red_next   = 1'b1;
		end
		else if (oper_ready_in && link_cyclic_in)
		begin
			mode_next  = MSL_GREEN;
			green_next = 1'b1;
		end
	end

	// registered led drive
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			led_green_out <= 1'b0;
			led_red_out   <= 1'b0;
			led_mode_out  <= MSL_DARK;
		end
		else
		begin
			led_green_out <= green_next;
			led_red_out   <= red_next;
			led_mode_out  <= mode_next;
		end
	end

	chk_green_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(oper_ready_in && link_cyclic_in && !link_setup_in && !fault_active_in && !fw_dl_busy_in
		&& !dl_done_latch_reg && !led_identify_setting_reg) |=> (led_green_out && !led_red_out))
		else $error("green not shown when ready");
	chk_orange_setup: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(link_setup_in && !fault_active_in && !fw_dl_busy_in && !dl_done_latch_reg
		&& !led_identify_setting_reg) |=> (led_green_out && led_red_out))
		else $error("orange not shown during setup");
	chk_red_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(fault_active_in && !fw_dl_busy_in && !dl_done_latch_reg && !led_identify_setting_reg)
		|=> (led_red_out && !led_green_out && led_mode_out == MSL_RED))
		else $error("red not shown on fault");
	chk_red_reconfig: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(fault_active_in && msg_reconfig_in && !fw_dl_busy_in && !dl_done_latch_reg && !led_identify_setting_reg)
		|=> (led_red_out && !led_green_out))
		else $error("reconfig suppressed red");
	chk_slow_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(slow_cnt_reg == 28'(SLOW_HALF - 1)) |=> (slow_ph_reg != $past(slow_ph_reg)))
		else $error("slow flash phase wrong");
	chk_slow_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(slow_cnt_reg != 28'(SLOW_HALF - 1))
		|=> (slow_cnt_reg == $past(slow_cnt_reg) + 28'h0000001 && $stable(slow_ph_reg)))
		else $error("slow divider step wrong");
	chk_done_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(dl_done_latch_reg && !led_identify_setting_reg)
		|=> (dl_done_latch_reg && led_mode_out == MSL_DL_FAST && led_green_out != led_red_out))
		else $error("download done pattern dropped");
	chk_ident_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(led_identify_setting_reg) |=> (led_mode_out == MSL_IDENT)[*2])
		else $error("identify pattern not shown");
	chk_prio_dl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(fw_dl_busy_in && fault_active_in && !led_identify_setting_reg && !dl_done_latch_reg)
		|=> led_mode_out == MSL_DL_SLOW)
		else $error("download not above fault");
endmodule
`default_nettype wire

// ### verification/msl_status_led_test.sv
// self-checking bench for the status led driver
`timescale 1ns/100ps
`default_nettype none
module msl_status_led_test;
	import msl_pkg::*;
	localparam logic [32:0] M_ALL = 33'h1_FFFF_FFFF;
	localparam logic [32:0] M_WR = 33'h1_0000_0000;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [6:0]  cond = 7'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rnd = 32'h0E2A_369C;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        led_green_out;
	logic        led_red_out;
	msl_mode_t   led_mode_out;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	logic [6:0]  tc[8] = '{7'h03, 7'h01, 7'h04, 7'h08, 7'h18, 7'h0F, 7'h28, 7'h00};
	logic [8:0]  te[8] = '{9'h009, 9'h013, 9'h013, 9'h022, 9'h022, 9'h022, 9'h041, 9'h004};
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	msl_status_led uut
	(
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.oper_ready_in(cond[0]), .link_cyclic_in(cond[1]), .link_setup_in(cond[2]),
		.fault_active_in(cond[3]), .msg_reconfig_in(cond[4]),
		.fw_dl_busy_in(cond[5]), .fw_dl_done_in(cond[6]),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.led_green_out(led_green_out), .led_red_out(led_red_out), .led_mode_out(led_mode_out)
	);
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task tally_and_finish;
		$display("compared %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one apb transfer; expected {pslverr, prdata} and mask queued
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		do @(posedge clk_in); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// apply conditions, then read status {mode, red, green}
	task stat(input logic [6:0] c, input logic [8:0] e, input logic [32:0] m);
		@(posedge clk_in);
		cond <= c;
		repeat (2) @(posedge clk_in);
		rnd = xs(rnd);
		apb(1'b0, 12'h004, rnd, {24'h0, e}, m);
	endtask
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// result watcher: oldest note against each completed transfer
	always @(posedge clk_in)
		if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
		begin
			check("apb", {pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	initial
	begin
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 33'h0, M_ALL);
		for (int i = 0; i < 8; i++)
			stat(tc[i], te[i], M_ALL);
		stat(7'h08, 9'h022, M_ALL);
		apb(1'b1, 12'h000, 32'h1, 33'h0, M_WR);
		apb(1'b0, 12'h000, 32'h0, 33'h1, 33'h1_0000_0001);
		stat(7'h08, 9'h102, 33'h1_FFFF_FFFE);
		stat(7'h28, 9'h102, 33'h1_FFFF_FFFE);
		apb(1'b1, 12'h000, 32'h0, 33'h0, M_WR);
		stat(7'h03, 9'h009, M_ALL);
		apb(1'b1, 12'h000, 32'h1, 33'h0, M_WR);
		stat(7'h03, 9'h101, 33'h1_FFFF_FFFD);
		stat(7'h0C, 9'h101, 33'h1_FFFF_FFFD);
		apb(1'b1, 12'h000, 32'h0, 33'h0, M_WR);
		rnd = xs(rnd);
		apb(1'b1, 12'h004, rnd, 33'h0, M_WR);
		stat(7'h03, 9'h009, M_ALL);
		rnd = xs(rnd);
		apb(1'b1, 12'h008, rnd, 33'h1_0000_0000, M_WR);
		apb(1'b0, 12'h00C, rnd, 33'h1_0000_0000, M_ALL);
		stat(7'h40, 9'h081, M_ALL);
		stat(7'h00, 9'h081, M_ALL);
		stat(7'h2B, 9'h081, M_ALL);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		stat(7'h00, 9'h004, M_ALL);
		tally_and_finish();
	end
endmodule
`default_nettype wire
